/* File: rtl/dce_pkg.sv */
// Constants and types shared by the debug command execution block.
package dce_pkg;
  // Command codes received from the debug host.
  localparam logic [7:0]  CMD_CRC   = 8'h0E;
  localparam logic [7:0]  CMD_STEP  = 8'h10;
  localparam logic [7:0]  CMD_STUFF = 8'h11;
  localparam logic [7:0]  CMD_EXEC  = 8'h12;
  // CRC-CCITT polynomial, start value and the value sent when not halted.
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_NODBG = 16'hFFFF;
  // Program memory geometry and option byte location.
  localparam int          PM_AW     = 13;
  localparam int          PM_BYTES  = 8192;
  localparam logic [12:0] OPT_ADDR  = 13'h0000;
  localparam int          OPT_FRP   = 2;
  // Register byte offsets on the bus.
  localparam logic [3:0]  REG_OPT   = 4'h0;
  localparam logic [3:0]  REG_CTRL  = 4'h4;
  localparam logic [3:0]  REG_STAT  = 4'h8;
  // Control register bit positions and value after reset.
  localparam int          CTRL_DBG  = 0;
  localparam int          CTRL_BRK  = 1;
  localparam int          CTRL_RST  = 2;
  localparam logic [1:0]  CTRL_RSTV = 2'h0;
  // Command sequencer states, one-hot.
  typedef enum logic [8:0] {
    ST_LOAD  = 9'h001,
    ST_LWAIT = 9'h002,
    ST_IDLE  = 9'h004,
    ST_CRC   = 9'h008,
    ST_TXHI  = 9'h010,
    ST_TXLO  = 9'h020,
    ST_STUFF = 9'h040,
    ST_EXEC  = 9'h080,
    ST_DISC  = 9'h100
  } dce_state_t;
endpackage

/* File: rtl/dce_debug_cmd.sv */
// Debug command executor with option byte and control register.
//
// Overview of operation
// RULE_01 - Command 0EH returns the CRC-CCITT of all program memory, high byte first.
// RULE_02 - Outside the halted debug state the CRC command returns FFFFH.
// RULE_03 - The CRC reply comes about one clock per memory byte after the command.
// RULE_04 - Command 10H executes one instruction at the program counter.
// RULE_05 - Step and stuff commands are ignored when not halted or read-protected.
// RULE_06 - Command 11H takes one opcode byte; the rest comes from program memory.
// RULE_07 - Command 12H forwards a whole 1-5 byte instruction to the core.
// RULE_08 - Command 12H when not allowed swallows exactly one byte and does nothing.
// RULE_09 - A control register enters/leaves debug, enables breakpoint, resets.
// RULE_10 - Bytes 0000H/0001H are option bits; read protect is bit 2 of 0000H.
// RULE_11 - The first option byte survives every reset and stays read/write.
// RULE_12 - Bytes go one at a time: command, then operands, then results.
//
// Local design decision: the Wishbone interface to the registers.
module dce_debug_cmd #(
  parameter int PM_SIZE = dce_pkg::PM_BYTES
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Byte link from and to the debug host.
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_tx_ready,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_byte,
  // Program memory read and option write port.
  output logic             o_pm_rd,
  output logic [12:0]      o_pm_addr,
  input  wire logic [7:0]  i_pm_data,
  output logic             o_opt_wr,
  output logic [7:0]       o_opt_wdata,
  // Core execution control.
  output logic             o_step,
  output logic             o_stuff,
  output logic [7:0]       o_opcode,
  output logic             o_exec_valid,
  output logic [7:0]       o_exec_byte,
  input  wire logic        i_exec_done,
  output logic             o_debug_mode,
  output logic             o_brk_en,
  output logic             o_dev_reset,
  output logic             o_read_protect,
  // Classic Wishbone slave.
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat
);

  // One CRC-CCITT step over a full byte, most significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ dce_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  localparam logic [13:0] PM_END = 14'(PM_SIZE);

  dce_pkg::dce_state_t st_q, st_d;
  logic [13:0] addr_q, addr_d;
  logic        pend_q, pend_d, fold_q, fold_d;
  logic [15:0] crc_q, crc_d;
  logic [7:0]  opt_q, opt_d;
  logic [1:0]  ctrl_q, ctrl_d;
  logic        rst_req;
  logic        opt_we;
  logic [7:0]  opt_wv;
  logic        allowed;
  logic        txv_d, pmrd_d, step_d, stuff_d, exv_d, optwr_d;
  logic [7:0]  txb_d, opc_d, exb_d, optwd_d;

  assign allowed = ctrl_q[dce_pkg::CTRL_DBG] & ~opt_q[dce_pkg::OPT_FRP];

  // Command sequencer and CRC engine next-state logic.
  always_comb begin
    st_d    = st_q;
    addr_d  = addr_q;
    pend_d  = 1'b0;
    fold_d  = 1'b0;
    crc_d   = crc_q;
    opt_d   = opt_q;
    txv_d   = o_tx_valid & ~i_tx_ready;
    txb_d   = o_tx_byte;
    pmrd_d  = 1'b0;
    step_d  = 1'b0;
    stuff_d = 1'b0;
    exv_d   = 1'b0;
    exb_d   = o_exec_byte;
    opc_d   = o_opcode;
    if (opt_we) begin
      opt_d = opt_wv; // RULE_11
    end
    case (st_q)
      dce_pkg::ST_LOAD: begin
        // Option byte reloads from flash after every reset.
        pmrd_d = 1'b1; // RULE_11
        st_d   = dce_pkg::ST_LWAIT;
      end
      dce_pkg::ST_LWAIT: begin
        if (pend_q) begin
          opt_d = i_pm_data; // RULE_10
          st_d  = dce_pkg::ST_IDLE;
        end else begin
          pend_d = 1'b1;
        end
      end
      dce_pkg::ST_IDLE: begin
        if (i_rx_valid) begin
          case (i_rx_byte) // RULE_12
            dce_pkg::CMD_CRC: begin
              addr_d = '0;
              if (ctrl_q[dce_pkg::CTRL_DBG]) begin
                crc_d = dce_pkg::CRC_INIT;
                st_d  = dce_pkg::ST_CRC;
              end else begin
                crc_d = dce_pkg::CRC_NODBG; // RULE_02
                st_d  = dce_pkg::ST_TXHI;
              end
            end
            dce_pkg::CMD_STEP: begin
              step_d = allowed; // RULE_04 RULE_05
            end
            dce_pkg::CMD_STUFF: begin
              if (allowed) begin // RULE_05
                st_d = dce_pkg::ST_STUFF;
              end
            end
            dce_pkg::CMD_EXEC: begin
              st_d = allowed ? dce_pkg::ST_EXEC
                             : dce_pkg::ST_DISC; // RULE_08
            end
            default: begin
              st_d = dce_pkg::ST_IDLE;
            end
          endcase
        end
      end
      dce_pkg::ST_CRC: begin
        // Data lands a cycle after the read pulse, so each fold lags by two.
        if (addr_q < PM_END) begin
          pmrd_d = 1'b1; // RULE_03
          pend_d = 1'b1;
          addr_d = addr_q + 14'h0001;
        end
        fold_d = pend_q;
        if (fold_q) begin
          crc_d = crc_byte(crc_q, i_pm_data); // RULE_01
        end
        if (addr_q == PM_END && !pend_q && !fold_q) begin
          st_d = dce_pkg::ST_TXHI;
        end
      end
      dce_pkg::ST_TXHI: begin
        if (!o_tx_valid || i_tx_ready) begin
          txv_d = 1'b1;
          txb_d = crc_q[15:8]; // RULE_01
          st_d  = dce_pkg::ST_TXLO;
        end
      end
      dce_pkg::ST_TXLO: begin
        if (i_tx_ready) begin
          txv_d = 1'b1;
          txb_d = crc_q[7:0]; // RULE_01
          st_d  = dce_pkg::ST_IDLE;
        end
      end
      dce_pkg::ST_STUFF: begin
        if (i_rx_valid) begin
          stuff_d = 1'b1; // RULE_06
          opc_d   = i_rx_byte;
          st_d    = dce_pkg::ST_IDLE;
        end
      end
      dce_pkg::ST_EXEC: begin
        // Bytes pass to the core until it reports the instruction done.
        if (i_exec_done) begin
          st_d = dce_pkg::ST_IDLE;
        end else if (i_rx_valid) begin
          exv_d = 1'b1; // RULE_07
          exb_d = i_rx_byte;
        end
      end
      dce_pkg::ST_DISC: begin
        if (i_rx_valid) begin
          st_d = dce_pkg::ST_IDLE; // RULE_08
        end
      end
      default: begin
        st_d = dce_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and flopped outputs.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q         <= dce_pkg::ST_LOAD;
      addr_q       <= '0;
      pend_q       <= 1'b0;
      fold_q       <= 1'b0;
      crc_q        <= dce_pkg::CRC_INIT;
      opt_q        <= 8'hFF;
      o_tx_valid   <= 1'b0;
      o_tx_byte    <= 8'h00;
      o_pm_rd      <= 1'b0;
      o_pm_addr    <= dce_pkg::OPT_ADDR;
      o_step       <= 1'b0;
      o_stuff      <= 1'b0;
      o_opcode     <= 8'h00;
      o_exec_valid <= 1'b0;
      o_exec_byte  <= 8'h00;
    end else begin
      st_q         <= st_d;
      addr_q       <= addr_d;
      pend_q       <= pend_d;
      fold_q       <= fold_d;
      crc_q        <= crc_d;
      opt_q        <= opt_d;
      o_tx_valid   <= txv_d;
      o_tx_byte    <= txb_d;
      o_pm_rd      <= pmrd_d;
      o_pm_addr    <= (st_q == dce_pkg::ST_CRC) ? addr_q[12:0]
                                                : dce_pkg::OPT_ADDR;
      o_step       <= step_d;
      o_stuff      <= stuff_d;
      o_opcode     <= opc_d;
      o_exec_valid <= exv_d;
      o_exec_byte  <= exb_d;
    end
  end

  // Bus decode: ack one cycle after a request, dropped the next cycle.
  logic        req;
  logic        ack_d, optwr_dd, dev_rst_d;
  logic [31:0] rdat_d;
  assign req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign opt_we = req & i_wb_we & i_wb_sel[0] & (i_wb_adr == dce_pkg::REG_OPT);
  assign opt_wv = i_wb_dat[7:0];
  assign rst_req = req & i_wb_we & i_wb_sel[0]
                 & (i_wb_adr == dce_pkg::REG_CTRL)
                 & i_wb_dat[dce_pkg::CTRL_RST];

  always_comb begin
    ack_d     = req;
    ctrl_d    = ctrl_q;
    rdat_d    = 32'h0000_0000;
    optwr_dd  = opt_we;
    optwd_d   = opt_we ? opt_wv : o_opt_wdata;
    dev_rst_d = rst_req; // RULE_09
    if (req && i_wb_we && i_wb_sel[0] && i_wb_adr == dce_pkg::REG_CTRL) begin
      ctrl_d = i_wb_dat[1:0]; // RULE_09
    end
    if (req && !i_wb_we) begin
      case (i_wb_adr)
        dce_pkg::REG_OPT:  rdat_d = {24'h000000, opt_q};
        dce_pkg::REG_CTRL: rdat_d = {30'h0, ctrl_q};
        dce_pkg::REG_STAT: rdat_d = {23'h0, st_q};
        default:           rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers; the control bits clear on reset, the option byte reloads.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack    <= 1'b0;
      o_wb_dat    <= 32'h0000_0000;
      ctrl_q      <= dce_pkg::CTRL_RSTV;
      o_opt_wr    <= 1'b0;
      o_opt_wdata <= 8'h00;
      o_dev_reset <= 1'b0;
    end else begin
      o_wb_ack    <= ack_d;
      o_wb_dat    <= rdat_d;
      ctrl_q      <= ctrl_d;
      o_opt_wr    <= optwr_dd;
      o_opt_wdata <= optwd_d;
      o_dev_reset <= dev_rst_d;
    end
  end

  // Mode outputs mirror their registers.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_debug_mode   <= 1'b0;
      o_brk_en       <= 1'b0;
      o_read_protect <= 1'b1;
    end else begin
      o_debug_mode   <= ctrl_q[dce_pkg::CTRL_DBG];
      o_brk_en       <= ctrl_q[dce_pkg::CTRL_BRK];
      o_read_protect <= opt_q[dce_pkg::OPT_FRP]; // RULE_10
    end
  end

  // Checks on the command behaviour.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_crc_nodebug: assert property ( // RULE_02
    st_q == dce_pkg::ST_IDLE && i_rx_valid && i_rx_byte == dce_pkg::CMD_CRC
    && !ctrl_q[dce_pkg::CTRL_DBG] |=> crc_q == 16'hFFFF
    && st_q == dce_pkg::ST_TXHI)
    else $error("CRC not forced outside debug");
  a_crc_order: assert property ( // RULE_01
    st_q == dce_pkg::ST_TXHI && st_d == dce_pkg::ST_TXLO
    |=> o_tx_valid && o_tx_byte == $past(crc_q[15:8]))
    else $error("CRC high byte not sent first");
  a_crc_walk: assert property ( // RULE_03
    $rose(st_q == dce_pkg::ST_CRC) |-> o_pm_rd == 1'b0 ##1 o_pm_rd)
    else $error("CRC read did not start");
  a_step_gate: assert property ( // RULE_05
    o_step |-> $past(allowed) && $past(i_rx_byte) == dce_pkg::CMD_STEP)
    else $error("Step issued while not allowed");
  a_step_once: assert property ( // RULE_04
    o_step |=> !o_step)
    else $error("Step longer than one cycle");
  a_stuff_byte: assert property ( // RULE_06
    st_q == dce_pkg::ST_STUFF && i_rx_valid
    |=> o_stuff && o_opcode == $past(i_rx_byte) && st_q == dce_pkg::ST_IDLE)
    else $error("Stuffed opcode wrong");
  a_exec_fwd: assert property ( // RULE_07
    st_q == dce_pkg::ST_EXEC && i_rx_valid && !i_exec_done
    |=> o_exec_valid && o_exec_byte == $past(i_rx_byte))
    else $error("Exec byte not forwarded");
  a_exec_discard: assert property ( // RULE_08
    st_q == dce_pkg::ST_DISC && i_rx_valid
    |=> st_q == dce_pkg::ST_IDLE && !o_exec_valid)
    else $error("Discarded byte mishandled");
  a_ctrl_write: assert property ( // RULE_09
    req && i_wb_we && i_wb_sel[0] && i_wb_adr == dce_pkg::REG_CTRL
    |=> ##1 o_debug_mode == $past(i_wb_dat[0], 2))
    else $error("Debug mode not written");
  a_opt_write: assert property ( // RULE_11
    opt_we && st_q != dce_pkg::ST_LWAIT |=> opt_q == $past(opt_wv))
    else $error("Option byte not written");
  a_ack_pulse: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("Ack held too long");

  c_crc_done: cover property (st_q == dce_pkg::ST_TXLO && i_tx_ready);
  c_stuff:    cover property (o_stuff);
  c_exec:     cover property (o_exec_valid ##[1:8] i_exec_done);
  c_discard:  cover property (st_q == dce_pkg::ST_DISC && i_rx_valid);
endmodule

/* File: verif/dce_host_model.sv */
// Debug host model that sends command bytes and takes reply bytes.
module dce_host_model (
  // Clock.
  input  wire logic       i_clk,
  // Byte link towards the block.
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_tx_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_byte
);
  timeunit 1ns;
  timeprecision 1ns;

  // The link is quiet until the first byte goes out.
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte  = 8'h00;
    o_tx_ready = 1'b0;
  end

  // One byte per pulse; the released line shows the inverse value.
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_byte  <= b;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_byte  <= ~b;
  endtask

  // Waits for a reply byte, stalls, then takes it at the ready edge.
  task automatic recv(input int stall, output logic [7:0] b);
    do @(posedge i_clk); while (i_tx_valid !== 1'b1);
    repeat (stall) @(posedge i_clk);
    o_tx_ready <= 1'b1;
    @(posedge i_clk);
    b = i_tx_byte;
    o_tx_ready <= 1'b0;
  endtask
endmodule

/* File: verif/tb.sv */
// Self-checking testbench for the debug command executor.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PMS = 16;

  logic        i_clk, i_rst_n, rx_v, tx_rdy, tx_v, pm_rd, opt_wr;
  logic        step, stuff, ex_v, ex_done, dbg, breakpoint_instruction, dev_rst, rprot;
  logic        cyc, stb, we, ack;
  logic [7:0]  rx_b, tx_b, pm_data, opt_wd, opcode, ex_b;
  logic [7:0]  hi, lo, last_op, last_ex;
  logic [7:0]  mem [PMS];
  logic [12:0] pm_addr;
  logic [3:0]  adr, sel, wsel;
  logic [31:0] wdat, rdat, q;
  int          failures, n_tests, n_step, n_stuff, n_exec, n_rst, now, t0;

  // Clock of 50 ns period.
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  dce_host_model u_host (.i_clk(i_clk), .o_rx_valid(rx_v),
    .o_rx_byte(rx_b), .o_tx_ready(tx_rdy), .i_tx_valid(tx_v),
    .i_tx_byte(tx_b));

  dce_debug_cmd #(.PM_SIZE(PMS)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_rx_valid(rx_v), .i_rx_byte(rx_b), .i_tx_ready(tx_rdy),
    .o_tx_valid(tx_v), .o_tx_byte(tx_b), .o_pm_rd(pm_rd),
    .o_pm_addr(pm_addr), .i_pm_data(pm_data), .o_opt_wr(opt_wr),
    .o_opt_wdata(opt_wd), .o_step(step), .o_stuff(stuff),
    .o_opcode(opcode), .o_exec_valid(ex_v), .o_exec_byte(ex_b),
    .i_exec_done(ex_done), .o_debug_mode(dbg), .o_brk_en(breakpoint_instruction),
    .o_dev_reset(dev_rst), .o_read_protect(rprot), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat));

  // Memory answers one edge after a read; option writes land at byte 0.
  always @(posedge i_clk) begin
    pm_data <= pm_rd ? mem[pm_addr[3:0]] : ~pm_data;
    if (opt_wr) mem[0] <= opt_wd;
    now <= now + 1;
    if (step) n_step <= n_step + 1;
    if (stuff) n_stuff <= n_stuff + 1;
    if (stuff) last_op <= opcode;
    if (ex_v) n_exec <= n_exec + 1;
    if (ex_v) last_ex <= ex_b;
    if (dev_rst) n_rst <= n_rst + 1;
  end

  // Compares one result and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single bus cycle; read data is left in q.
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d);
    @(posedge i_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= wsel;
    // Waits for ack however long it takes; the watchdog ends a hang.
    do @(posedge i_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic do_reset();
    i_rst_n <= 1'b0;
    tick(12);
    i_rst_n <= 1'b1;
    tick(4);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Reference CRC, MSB first, over the whole memory image.
  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < PMS; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  // Cuts a hang short well past the expected run length.
  initial begin
    tick(4000);
    failures++;
    stop_test();
  end

  // Main sequence of tests.
  initial begin
    {i_rst_n, cyc, stb, we, ex_done} = 5'h00;
    adr     = 4'h0;
    sel     = 4'hF;
    wsel    = 4'hF;
    wdat    = 32'h0;
    pm_data = 8'h00;
    for (int i = 0; i < PMS; i++) mem[i] = 8'(i) * 8'h25 ^ 8'h80;
    do_reset();
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h80);
    chk(rprot, 1'b0);
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'(dce_pkg::ST_IDLE));
    done("registers");
    u_host.send(8'h0E);
    u_host.recv(3, hi);
    u_host.recv(0, lo);
    chk({hi, lo}, 32'hFFFF);
    u_host.send(8'h10);
    tick(3);
    chk(n_step, 0);
    done("not halted");
    wb(1'b1, 4'h4, 32'h7);
    tick(2);
    chk({breakpoint_instruction, dbg}, 2'h3);
    chk(n_rst, 1);
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h3);
    t0 = now;
    u_host.send(8'h0E);
    u_host.recv(0, hi);
    u_host.recv(5, lo);
    chk({hi, lo}, crc_exp());
    chk(now - t0 >= PMS, 1'b1);
    u_host.send(8'h10);
    tick(2);
    chk(n_step, 1);
    u_host.send(8'h11);
    u_host.send(8'hA5);
    tick(2);
    chk(n_stuff, 1);
    chk(last_op, 8'hA5);
    u_host.send(8'h12);
    u_host.send(8'h3C);
    u_host.send(8'h7E);
    ex_done <= 1'b1;
    tick(1);
    ex_done <= 1'b0;
    tick(2);
    chk(n_exec, 2);
    chk(last_ex, 8'h7E);
    done("halted");
    wsel = 4'hE;
    wb(1'b1, 4'h0, 32'h84);
    wsel = 4'hF;
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h80);
    wb(1'b1, 4'h0, 32'h84);
    tick(2);
    chk(rprot, 1'b1);
    u_host.send(8'h10);
    u_host.send(8'h11);
    u_host.send(8'h12);
    u_host.send(8'h0E);
    tick(30);
    chk(tx_v, 1'b0);
    chk(n_step + n_stuff + n_exec, 4);
    done("protected");
    do_reset();
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h84);
    chk(rprot, 1'b1);
    wb(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    done("second reset");
    stop_test();
  end
endmodule
